// [rtl/stc_pkg.sv]
// Shared constants and types for the sensor thermal control block
package stc_pkg;

    // ------------------------------------------------------------
    // Widths and clock
    // ------------------------------------------------------------
    localparam int unsigned TEMP_W   = 16;
    localparam int unsigned PWR_W    = 8;
    localparam int unsigned LVL_W    = 3;
    localparam int unsigned CLK_MHZ  = 100;

    // ------------------------------------------------------------
    // Timing: setpoint slew step, one LSB per step
    // ------------------------------------------------------------
    localparam int unsigned STEP_TIME_US = 10;
    localparam int unsigned STEP_CYC     = STEP_TIME_US * CLK_MHZ;

    // ------------------------------------------------------------
    // Regulation gain, as a left shift of the temperature error
    // ------------------------------------------------------------
    localparam int unsigned GAIN_SH = 3;

    // ------------------------------------------------------------
    // Five drive levels, off to high
    // ------------------------------------------------------------
    typedef enum logic [LVL_W-1:0] {
        LV_OFF     = 3'h0,
        LV_LOW     = 3'h1,
        LV_MID     = 3'h2,
        LV_MIDHIGH = 3'h3,
        LV_HIGH    = 3'h4
    } stc_level_t;

    // Duty per level; full scale means never low
    localparam logic [PWR_W-1:0] DUTY_OFF     = 8'h00;
    localparam logic [PWR_W-1:0] DUTY_LOW     = 8'h40;
    localparam logic [PWR_W-1:0] DUTY_MID     = 8'h80;
    localparam logic [PWR_W-1:0] DUTY_MIDHIGH = 8'hc0;
    localparam logic [PWR_W-1:0] DUTY_HIGH    = 8'hff;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic              COOLER_RST   = 1'b1;
    localparam stc_level_t        FAN_RST_LVL  = LV_HIGH;
    localparam stc_level_t        FAN_AUTO_LVL = LV_LOW;
    localparam stc_level_t        HEAT_RST_LVL = LV_OFF;
    localparam logic [TEMP_W-1:0] TARGET_RST   = 16'h0000;

    // ------------------------------------------------------------
    // Drive stage outputs
    // ------------------------------------------------------------
    typedef struct packed {
        logic cooler_pwm;
        logic fan_pwm;
        logic heater_pwm;
    } stc_drive_t;

endpackage

// [rtl/stc_pwm.sv]
// Pulse width generator for one drive stage
`timescale 1ns/1ps
module stc_pwm #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    // Duty and output
    input  wire logic [W-1:0] duty_i,
    output logic              pwm_o
);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         pwm_nxt;

    // Counter wraps one short of full scale, so full duty stays high
    always_comb
    begin
        cnt_nxt = (cnt_r == {{(W-1){1'b1}}, 1'b0}) ? '0 : cnt_r + 1'b1;
        pwm_nxt = (cnt_r < duty_i);
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cnt_r <= '0;
            pwm_o <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            pwm_o <= pwm_nxt;
        end
    end

endmodule

// [rtl/stc_thermal_ctrl.sv]
// Cooler, fan and anti-fog heater control for a cooled sensor
//
// Operation
// - Out of reset the cooler is enabled with no host action.
// - A new target slews the setpoint gradually while temperature is always reported.
// - The fan has five levels from off to high, and high runs it at full speed.
// - Choosing fan off stops the fan and disables the cooler, so cooler power reads zero.
// - Enabling the cooler switches the fan on automatically.
// - The anti-fog heater has five levels from off to high.
`timescale 1ns/1ps
module stc_thermal_ctrl (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        sys_rst_i,
    // Host cooler control
    input  wire logic                        cooler_on_i,
    input  wire logic                        cooler_off_i,
    input  wire logic                        target_wr_i,
    input  wire logic [stc_pkg::TEMP_W-1:0]  target_temp_i,
    // Host fan and heater control
    input  wire logic                        fan_wr_i,
    input  wire logic [stc_pkg::LVL_W-1:0]   fan_level_i,
    input  wire logic                        heater_wr_i,
    input  wire logic [stc_pkg::LVL_W-1:0]   heater_level_i,
    // Temperature measurement, same clock
    input  wire logic                        sensor_valid_i,
    input  wire logic [stc_pkg::TEMP_W-1:0]  sensor_temp_i,
    // Status
    output logic                             cooler_on_o,
    output logic [stc_pkg::TEMP_W-1:0]       current_temp_o,
    output logic [stc_pkg::TEMP_W-1:0]       setpoint_o,
    output logic [stc_pkg::PWR_W-1:0]        cooler_power_o,
    output logic [stc_pkg::LVL_W-1:0]        fan_level_o,
    output logic [stc_pkg::LVL_W-1:0]        heater_level_o,
    // Drive stages
    output stc_pkg::stc_drive_t              drive_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic stc_pkg::stc_level_t clamp_level(input logic [stc_pkg::LVL_W-1:0] v);
        clamp_level = (v > stc_pkg::LV_HIGH) ? stc_pkg::LV_HIGH : stc_pkg::stc_level_t'(v);
    endfunction

    function automatic logic [stc_pkg::PWR_W-1:0] level_duty(input stc_pkg::stc_level_t l);
        case (l)
            stc_pkg::LV_LOW:     level_duty = stc_pkg::DUTY_LOW;
            stc_pkg::LV_MID:     level_duty = stc_pkg::DUTY_MID;
            stc_pkg::LV_MIDHIGH: level_duty = stc_pkg::DUTY_MIDHIGH;
            stc_pkg::LV_HIGH:    level_duty = stc_pkg::DUTY_HIGH;
            default:             level_duty = stc_pkg::DUTY_OFF;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Cooler enable and level settings
    // ------------------------------------------------------------
    logic                cooler_en_r;
    logic                cooler_en_nxt;
    stc_pkg::stc_level_t fan_lvl_r;
    stc_pkg::stc_level_t fan_lvl_nxt;
    stc_pkg::stc_level_t heat_lvl_r;
    stc_pkg::stc_level_t heat_lvl_nxt;

    always_comb
    begin
        cooler_en_nxt = cooler_en_r;
        fan_lvl_nxt   = fan_lvl_r;
        heat_lvl_nxt  = heat_lvl_r;
        if (fan_wr_i)
        begin
            fan_lvl_nxt = clamp_level(fan_level_i);
        end
        if (heater_wr_i)
        begin
            heat_lvl_nxt = clamp_level(heater_level_i);
        end
        if (cooler_on_i)
        begin
            cooler_en_nxt = 1'b1;
        end
        else if (cooler_off_i)
        begin
            cooler_en_nxt = 1'b0;
        end
        // Explicit fan off wins over a same-cycle cooler on: never cool unventilated
        if (fan_wr_i && fan_lvl_nxt == stc_pkg::LV_OFF)
        begin
            cooler_en_nxt = 1'b0;
        end
        else if (cooler_en_nxt && fan_lvl_nxt == stc_pkg::LV_OFF)
        begin
            fan_lvl_nxt = stc_pkg::FAN_AUTO_LVL;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cooler_en_r <= stc_pkg::COOLER_RST;
            fan_lvl_r   <= stc_pkg::FAN_RST_LVL;
            heat_lvl_r  <= stc_pkg::HEAT_RST_LVL;
        end
        else
        begin
            cooler_en_r <= cooler_en_nxt;
            fan_lvl_r   <= fan_lvl_nxt;
            heat_lvl_r  <= heat_lvl_nxt;
        end
    end

    // ------------------------------------------------------------
    // Target, slewed setpoint, measured temperature, cooler power
    // ------------------------------------------------------------
    localparam logic [15:0] STEP_LAST = 16'(stc_pkg::STEP_CYC - 1);

    logic signed [stc_pkg::TEMP_W-1:0] target_r;
    logic signed [stc_pkg::TEMP_W-1:0] target_nxt;
    logic signed [stc_pkg::TEMP_W-1:0] setpt_r;
    logic signed [stc_pkg::TEMP_W-1:0] setpt_nxt;
    logic signed [stc_pkg::TEMP_W-1:0] temp_r;
    logic signed [stc_pkg::TEMP_W-1:0] temp_nxt;
    logic [15:0]                       step_cnt_r;
    logic [15:0]                       step_cnt_nxt;
    logic [stc_pkg::PWR_W-1:0]         power_r;
    logic [stc_pkg::PWR_W-1:0]         power_nxt;
    logic                              step_tick;
    logic signed [stc_pkg::TEMP_W:0]   err;
    logic signed [stc_pkg::TEMP_W+8:0] err_sh;

    assign step_tick = (step_cnt_r == STEP_LAST);

    always_comb
    begin
        target_nxt   = target_wr_i ? $signed(target_temp_i) : target_r;
        step_cnt_nxt = step_tick ? 16'h0000 : step_cnt_r + 16'h0001;
        setpt_nxt    = setpt_r;
        // One LSB per step keeps the sensor from a thermal shock
        if (step_tick && setpt_r < target_r)
        begin
            setpt_nxt = setpt_r + 16'sh0001;
        end
        else if (step_tick && setpt_r > target_r)
        begin
            setpt_nxt = setpt_r - 16'sh0001;
        end
        temp_nxt = sensor_valid_i ? $signed(sensor_temp_i) : temp_r;
        err      = {temp_r[stc_pkg::TEMP_W-1], temp_r} - {setpt_r[stc_pkg::TEMP_W-1], setpt_r};
        err_sh   = {{8{err[stc_pkg::TEMP_W]}}, err} <<< stc_pkg::GAIN_SH;
        if (!cooler_en_r || err <= 0)
        begin
            power_nxt = '0;
        end
        else if (err_sh > 25'sd255)
        begin
            power_nxt = 8'hff;
        end
        else
        begin
            power_nxt = err_sh[stc_pkg::PWR_W-1:0];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            target_r   <= stc_pkg::TARGET_RST;
            setpt_r    <= stc_pkg::TARGET_RST;
            temp_r     <= '0;
            step_cnt_r <= 16'h0000;
            power_r    <= '0;
        end
        else
        begin
            target_r   <= target_nxt;
            setpt_r    <= setpt_nxt;
            temp_r     <= temp_nxt;
            step_cnt_r <= step_cnt_nxt;
            power_r    <= power_nxt;
        end
    end

    // ------------------------------------------------------------
    // Drive stages and status
    // ------------------------------------------------------------
    logic cool_pwm;
    logic fan_pwm;
    logic heat_pwm;

    stc_pwm #(.W(stc_pkg::PWR_W)) u_cool_pwm (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .duty_i    (power_r),
        .pwm_o     (cool_pwm)
    );

    stc_pwm #(.W(stc_pkg::PWR_W)) u_fan_pwm (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .duty_i    (level_duty(fan_lvl_r)),
        .pwm_o     (fan_pwm)
    );

    stc_pwm #(.W(stc_pkg::PWR_W)) u_heat_pwm (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .duty_i    (level_duty(heat_lvl_r)),
        .pwm_o     (heat_pwm)
    );

    assign drive_o        = '{cooler_pwm: cool_pwm, fan_pwm: fan_pwm, heater_pwm: heat_pwm};
    assign cooler_on_o    = cooler_en_r;
    assign current_temp_o = temp_r;
    assign setpoint_o     = setpt_r;
    assign cooler_power_o = power_r;
    assign fan_level_o    = fan_lvl_r;
    assign heater_level_o = heat_lvl_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_reset_cooler_on;
        $past(sys_rst_i) |-> cooler_en_r && fan_lvl_r != stc_pkg::LV_OFF;
    endproperty
    a_reset_cooler_on: assert property (p_reset_cooler_on)
        else $error("cooler not enabled after reset");

    property p_setpoint_slew;
        (setpt_r != $past(setpt_r)) |-> $past(step_tick)
            && (setpt_r - $past(setpt_r) == 16'sh0001 || $past(setpt_r) - setpt_r == 16'sh0001);
    endproperty
    a_setpoint_slew: assert property (p_setpoint_slew)
        else $error("setpoint moved other than one step on a tick");

    property p_setpoint_up;
        step_tick && setpt_r < target_r |=> setpt_r == $past(setpt_r) + 16'sh0001;
    endproperty
    a_setpoint_up: assert property (p_setpoint_up)
        else $error("setpoint failed to rise toward target");

    property p_temp_report;
        sensor_valid_i |=> current_temp_o == $past(sensor_temp_i);
    endproperty
    a_temp_report: assert property (p_temp_report)
        else $error("reported temperature not updated");

    property p_fan_full;
        (fan_lvl_r == stc_pkg::LV_HIGH)[*2] |-> drive_o.fan_pwm;
    endproperty
    a_fan_full: assert property (p_fan_full)
        else $error("fan not at full drive on high");

    property p_fan_off_cooler;
        fan_wr_i && fan_level_i == 3'h0 |=> !cooler_on_o && fan_level_o == 3'h0
            ##1 cooler_power_o == 8'h00;
    endproperty
    a_fan_off_cooler: assert property (p_fan_off_cooler)
        else $error("fan off did not stop cooler");

    property p_interlock;
        cooler_on_o |-> fan_level_o != 3'h0;
    endproperty
    a_interlock: assert property (p_interlock)
        else $error("cooler on with fan stopped");

    property p_cooler_idle;
        !cooler_on_o |=> cooler_power_o == 8'h00;
    endproperty
    a_cooler_idle: assert property (p_cooler_idle)
        else $error("cooler power not zero while cooler disabled");

    property p_heater_off;
        (heat_lvl_r == stc_pkg::LV_OFF)[*2] |-> !drive_o.heater_pwm;
    endproperty
    a_heater_off: assert property (p_heater_off)
        else $error("heater driven while off");

    property p_status_fan;
        fan_wr_i && fan_level_i != 3'h0 && fan_level_i <= 3'h4
            |=> fan_level_o == $past(fan_level_i);
    endproperty
    a_status_fan: assert property (p_status_fan)
        else $error("fan status does not show selected level");

    c_fan_off: cover property (fan_wr_i && fan_level_i == 3'h0 && cooler_on_o);
    c_setpoint_step: cover property (step_tick && setpt_r != target_r);
    c_heater_high: cover property (heat_lvl_r == stc_pkg::LV_HIGH && drive_o.heater_pwm);
    c_auto_fan: cover property (cooler_on_i && fan_lvl_r == stc_pkg::LV_OFF);

endmodule

// [verification/stc_drive_meter.sv]
// Drive stage model: counts high cycles of each drive bit over one PWM period
`timescale 1ns/1ps
module stc_drive_meter (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    // Measurement control
    input  wire logic                start_i,
    output logic                     done_o,
    // Drive stage inputs and measured on-times
    input  wire stc_pkg::stc_drive_t drive_i,
    output logic [8:0]               cool_cnt_o,
    output logic [8:0]               fan_cnt_o,
    output logic [8:0]               heat_cnt_o
);
    logic [7:0] win_r;
    logic       busy_r;

    // ------------------------------------------------------------
    // Window of 255 samples, one full PWM period
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            win_r      <= 8'h00;
            busy_r     <= 1'b0;
            done_o     <= 1'b0;
            cool_cnt_o <= 9'h000;
            fan_cnt_o  <= 9'h000;
            heat_cnt_o <= 9'h000;
        end
        else if (start_i)
        begin
            win_r      <= 8'h00;
            busy_r     <= 1'b1;
            done_o     <= 1'b0;
            cool_cnt_o <= 9'h000;
            fan_cnt_o  <= 9'h000;
            heat_cnt_o <= 9'h000;
        end
        else if (busy_r)
        begin
            // Exactly one period, so the count equals the duty
            cool_cnt_o <= cool_cnt_o + 9'(drive_i.cooler_pwm);
            fan_cnt_o  <= fan_cnt_o + 9'(drive_i.fan_pwm);
            heat_cnt_o <= heat_cnt_o + 9'(drive_i.heater_pwm);
            win_r      <= win_r + 8'h01;
            if (win_r == 8'hfe)
            begin
                busy_r <= 1'b0;
                done_o <= 1'b1;
            end
        end
    end
endmodule

// [verification/stc_thermal_ctrl_tb.sv]
// Self-checking bench for the sensor thermal control block
`timescale 1ns/1ps
module stc_thermal_ctrl_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                clk_i     = 1'b0;
    logic                sys_rst_i = 1'b1;
    logic                con       = 1'b0;
    logic                coff      = 1'b0;
    logic                twr       = 1'b0;
    logic                fwr       = 1'b0;
    logic                hwr       = 1'b0;
    logic                sv        = 1'b0;
    logic                start     = 1'b0;
    logic [2:0]          fl        = 3'h0;
    logic [2:0]          hl        = 3'h0;
    logic [15:0]         tv        = 16'h0000;
    logic                cool_o;
    logic [15:0]         temp_o;
    logic [15:0]         sp_o;
    logic [7:0]          pwr_o;
    logic [2:0]          fan_o;
    logic [2:0]          heat_o;
    stc_pkg::stc_drive_t drv;
    logic                done;
    logic [8:0]          cc;
    logic [8:0]          fc;
    logic [8:0]          hc;
    int                  error_cnt = 0;
    int                  checks    = 0;
    int                  n;
    localparam logic [7:0] DUTY [5] = '{stc_pkg::DUTY_OFF, stc_pkg::DUTY_LOW,
        stc_pkg::DUTY_MID, stc_pkg::DUTY_MIDHIGH, stc_pkg::DUTY_HIGH};
    // Rows: fan in, heater in, fan expected, heater expected, cooler expected
    localparam logic [12:0] ROWS [8] = '{
        {3'h4, 3'h0, 3'h4, 3'h0, 1'h1}, {3'h3, 3'h1, 3'h3, 3'h1, 1'h1},
        {3'h2, 3'h2, 3'h2, 3'h2, 1'h1}, {3'h1, 3'h3, 3'h1, 3'h3, 1'h1},
        {3'h7, 3'h4, 3'h4, 3'h4, 1'h1}, {3'h5, 3'h6, 3'h4, 3'h4, 1'h1},
        {3'h0, 3'h5, 3'h0, 3'h4, 1'h0}, {3'h6, 3'h7, 3'h4, 3'h4, 1'h0}};

    always #5 clk_i = ~clk_i;

    stc_thermal_ctrl u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cooler_on_i(con),
        .cooler_off_i(coff), .target_wr_i(twr), .target_temp_i(tv), .fan_wr_i(fwr),
        .fan_level_i(fl), .heater_wr_i(hwr), .heater_level_i(hl), .sensor_valid_i(sv),
        .sensor_temp_i(tv), .cooler_on_o(cool_o), .current_temp_o(temp_o),
        .setpoint_o(sp_o), .cooler_power_o(pwr_o), .fan_level_o(fan_o),
        .heater_level_o(heat_o), .drive_o(drv));
    stc_drive_meter u_meter (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start),
        .done_o(done), .drive_i(drv), .cool_cnt_o(cc), .fan_cnt_o(fc), .heat_cnt_o(hc));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Strobes last one cycle; returns once power has also settled
    task automatic put(input logic f, input logic [2:0] fv, input logic h,
                       input logic [2:0] hv, input logic on, input logic off);
        @(posedge clk_i);
        fwr  <= f;
        fl   <= fv;
        hwr  <= h;
        hl   <= hv;
        con  <= on;
        coff <= off;
        @(posedge clk_i);
        fwr  <= 1'b0;
        hwr  <= 1'b0;
        con  <= 1'b0;
        coff <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    task automatic val(input logic t, input logic s, input logic [15:0] v);
        @(posedge clk_i);
        twr <= t;
        sv  <= s;
        tv  <= v;
        @(posedge clk_i);
        twr <= 1'b0;
        sv  <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic meas(input logic [7:0] c, input logic [7:0] f, input logic [7:0] h);
        int k;
        @(posedge clk_i);
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        #1;
        k = 0;
        while (done !== 1'b1 && k < 400)
        begin
            @(posedge clk_i);
            #1;
            k++;
        end
        if (k >= 400)
        begin
            error_cnt++;
            print_verdict();
        end
        check(16'(cc), 16'(c));
        check(16'(fc), 16'(f));
        check(16'(hc), 16'(h));
    endtask

    task automatic rst_chk();
        check(16'(cool_o), 16'h0001);
        check(16'(fan_o), 16'h0004);
        check(16'(heat_o), 16'h0000);
        check(16'(pwr_o), 16'h0000);
        check(sp_o, 16'h0000);
        check(temp_o, 16'h0000);
        check(16'(drv), 16'h0000);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk_i);
        #1;
        rst_chk();
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            put(1'b1, ROWS[i][12:10], 1'b1, ROWS[i][9:7], 1'b0, 1'b0);
            check(16'(fan_o), 16'(ROWS[i][6:4]));
            check(16'(heat_o), 16'(ROWS[i][3:1]));
            check(16'(cool_o), 16'(ROWS[i][0]));
            check(16'(pwr_o), 16'h0000);
            meas(8'h00, DUTY[ROWS[i][6:4]], DUTY[ROWS[i][3:1]]);
        end
        // Cooler on with fan running keeps the chosen level
        put(1'b0, 3'h0, 1'b0, 3'h0, 1'b1, 1'b0);
        check(16'(cool_o), 16'h0001);
        check(16'(fan_o), 16'h0004);
        // Fan off beats a simultaneous cooler on
        put(1'b1, 3'h0, 1'b0, 3'h0, 1'b1, 1'b0);
        check(16'(cool_o), 16'h0000);
        check(16'(fan_o), 16'h0000);
        // Cooler on with fan stopped starts the fan
        put(1'b0, 3'h0, 1'b0, 3'h0, 1'b1, 1'b0);
        check(16'(cool_o), 16'h0001);
        check(16'(fan_o), 16'h0001);
        put(1'b0, 3'h0, 1'b0, 3'h0, 1'b1, 1'b1);
        check(16'(cool_o), 16'h0001);
        // Power follows error times eight, clamped, zero when colder
        val(1'b0, 1'b1, 16'h000a);
        check(temp_o, 16'h000a);
        check(16'(pwr_o), 16'h0050);
        meas(8'h50, DUTY[1], DUTY[4]);
        val(1'b0, 1'b1, 16'h0064);
        check(16'(pwr_o), 16'h00ff);
        put(1'b0, 3'h0, 1'b0, 3'h0, 1'b0, 1'b1);
        check(16'(pwr_o), 16'h0000);
        check(16'(fan_o), 16'h0001);
        put(1'b0, 3'h0, 1'b0, 3'h0, 1'b1, 1'b0);
        val(1'b0, 1'b1, 16'hfffb);
        check(temp_o, 16'hfffb);
        check(16'(pwr_o), 16'h0000);
        // Setpoint creeps one step per tick, never jumps
        val(1'b1, 1'b0, 16'h0003);
        check(16'(sp_o > 16'h0001), 16'h0000);
        n = 0;
        while (sp_o !== 16'h0003 && n < 5000)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 5000)
        begin
            error_cnt++;
            print_verdict();
        end
        check(16'(n >= 1990), 16'h0001);
        repeat (1100) @(posedge clk_i);
        #1;
        check(sp_o, 16'h0003);
        // Lower target: one step down within one tick period
        val(1'b1, 1'b0, 16'h0002);
        repeat (1000) @(posedge clk_i);
        #1;
        check(sp_o, 16'h0002);
        // Second reset in mid-run
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        @(posedge clk_i);
        #1;
        rst_chk();
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        check(16'(cool_o), 16'h0001);
        print_verdict();
    end
endmodule
